// ---- design/gdf_params.svh ----
/*
  Holds the constants of the port D/E/F data register block: addresses,
  bit masks, reset values and bus access codes.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef GDF_PARAMS_SVH
`define GDF_PARAMS_SVH

// register byte addresses on the processor bus
`define GDF_ADDR_PORT_D     32'h0400_0126
`define GDF_ADDR_PORT_E     32'h0400_0128
`define GDF_ADDR_PORT_F     32'h0400_012A

// bits backed by storage, one per pin
`define GDF_PD_WRITABLE     8'hAF
`define GDF_PE_WRITABLE     8'hFF
`define GDF_PF_WRITABLE     8'h00
`define GDF_PG_WRITABLE     8'h1F

// power-on reset values of the stored bits
`define GDF_PD_RESET        8'h00
`define GDF_PE_RESET        8'h00

// answer to a refused or unmapped read
`define GDF_RDATA_NONE      8'h00

// access size code of a byte access
`define GDF_SIZE_BYTE       2'h0

`endif

// ---- design/gdf_pkg.sv ----
/*
  Holds the types shared by the port D/E/F data register block.
  Assumes nothing of its surroundings.
*/
package gdf_pkg;

    // two-bit pin mode from the pin function controller
    typedef enum logic [1:0] {
        GDF_MODE_ALT     = 2'h0,
        GDF_MODE_OUT     = 2'h1,
        GDF_MODE_IN_PU   = 2'h2,
        GDF_MODE_IN_NOPU = 2'h3
    } gdf_mode_t;

    typedef enum logic {
        GDF_BUS_IDLE,
        GDF_BUS_RESP
    } gdf_bus_state_t;

endpackage : gdf_pkg

// ---- design/gdf_pin_sync.sv ----
/*
  Three-stage synchroniser for a group of pin inputs; a bit's level
  changes only once the second and third stages agree.
  Assumes the pins are asynchronous to sys_clk.
*/
module gdf_pin_sync
    import gdf_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // pins in, filtered level out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinLevel
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } gdf_sync_state_t;

    gdf_sync_state_t state_q;
    gdf_sync_state_t state_d;

    always_comb
    begin
        state_d        = state_q;
        state_d.stage1 = pinIn;
        state_d.stage2 = state_q.stage1;
        state_d.stage3 = state_q.stage2;
        // a bit follows only when stages two and three agree
        state_d.level  = (state_q.stage2 & ~(state_q.stage2 ^ state_q.stage3))
                       | (state_q.level & (state_q.stage2 ^ state_q.stage3));
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign pinLevel = state_q.level;

endmodule // gdf_pin_sync

// ---- design/gdf_port_bits.sv ----
/*
  Per-pin decode of one 8-bit port: read value, output enable and
  pull-up enable from the two-bit pin modes.
  Assumes modes are packed two bits per pin, pin n at [2n+1:2n].
*/
module gdf_port_bits
    import gdf_pkg::*;
#(
    parameter int               WIDTH    = 8,
    parameter logic [WIDTH-1:0] WRITABLE = '1
)
(
    // modes, stored bits and sampled pin levels
    input  wire logic [2*WIDTH-1:0] pinMode,
    input  wire logic [WIDTH-1:0]   stored,
    input  wire logic [WIDTH-1:0]   pinLevel,
    // decoded results
    output logic      [WIDTH-1:0]   readVal,
    output logic      [WIDTH-1:0]   driveEn,
    output logic      [WIDTH-1:0]   pullupEn
);

    for (genvar n = 0; n < WIDTH; n++)
    begin : g_bit
        gdf_mode_t mode;
        logic      isInput;

        assign mode    = gdf_mode_t'(pinMode[2*n +: 2]);
        assign isInput = (mode == GDF_MODE_IN_PU)
                      || (mode == GDF_MODE_IN_NOPU);

        // input modes read the pin, others the store or low level
        assign readVal[n] = isInput ? pinLevel[n]
                          : (WRITABLE[n] ? stored[n] : 1'b0);

        // only general output drives, on writable bits; alternate never drives
        assign driveEn[n]  = WRITABLE[n] && (mode == GDF_MODE_OUT);
        assign pullupEn[n] = (mode == GDF_MODE_IN_PU);
    end

endmodule // gdf_port_bits

// ---- design/gdf_port_data.sv ----
/*
  Data registers of general-purpose ports D, E and F, plus the pull-up
  enables of port G, reached over the processor's byte bus.
  Assumes pin modes come from the pin function controller, and that
  sys_rst is the power-on reset only.

// How it works
// - mode 00 alternate, 01 output, 10 input pull-up, 11 input no pull-up
// - port D bits 7,5,3,2,1,0 are stored; bits 6 and 4 read only
// - output or alternate mode reads the stored bit of a writable pin
// - either input mode reads the sampled pin level
// - output mode writes store the bit and drive it onto the pin
// - other modes still store writes but leave the pin alone
// - port D bits 6 and 4 read low except in input modes
// - writes to input-only bits are dropped and never reach pins
// - power-on: port D stored bits clear, pins input with pull-up
// - port D and E stores survive standby, sleep and manual reset
// - port E is eight stored bits cleared to 00 at power-on
// - port F is read only; input modes read pins, else 00
// - port F defaults to input with pull-up, contents undefined
// - a pull-up is on exactly in input-with-pull-up mode
// - port G has five bidirectional and three input-only bits
*/
`include "gdf_params.svh"

module gdf_port_data
    import gdf_pkg::*;
(
    // clock and power-on reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,

    // processor byte bus
    input  wire logic        busReq,
    input  wire logic        busWrite,
    input  wire logic [31:0] busAddr,
    input  wire logic [1:0]  busSize,
    input  wire logic [7:0]  busWdata,
    output logic      [7:0]  busRdata,
    output logic             busAck,
    output logic             busErr,

    // pin modes from the pin function controller
    input  wire logic [15:0] pdMode,
    input  wire logic [15:0] peMode,
    input  wire logic [15:0] pfMode,
    input  wire logic [15:0] pgMode,

    // port D pins
    input  wire logic [7:0]  pdPinIn,
    output logic      [7:0]  pdPinOut,
    output logic      [7:0]  pdPinOe,
    output logic      [7:0]  pdPullup,

    // port E pins
    input  wire logic [7:0]  pePinIn,
    output logic      [7:0]  pePinOut,
    output logic      [7:0]  pePinOe,
    output logic      [7:0]  pePullup,

    // port F pins
    input  wire logic [7:0]  pfPinIn,
    output logic      [7:0]  pfPullup,

    // port G pull-up enables
    output logic      [7:0]  pgPullup
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        gdf_bus_state_t busState;
        logic [7:0]     pdData;
        logic [7:0]     peData;
        logic [7:0]     rdata;
        logic           ack;
        logic           err;
    } gdf_state_t;

    gdf_state_t state_q;
    gdf_state_t state_d;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [7:0] pdLevel;
    logic [7:0] peLevel;
    logic [7:0] pfLevel;

    gdf_pin_sync #(
        .WIDTH    (8)
    ) u_pd_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pinIn    (pdPinIn),
        .pinLevel (pdLevel)
    );

    gdf_pin_sync #(
        .WIDTH    (8)
    ) u_pe_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pinIn    (pePinIn),
        .pinLevel (peLevel)
    );

    gdf_pin_sync #(
        .WIDTH    (8)
    ) u_pf_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pinIn    (pfPinIn),
        .pinLevel (pfLevel)
    );

    ////////////////////////////////////////////////////////////////////
    // per-pin mode decode

    logic [7:0] pdRead;
    logic [7:0] peRead;
    logic [7:0] pfRead;
    logic [7:0] pdDrive;
    logic [7:0] peDrive;

    gdf_port_bits #(
        .WIDTH    (8),
        .WRITABLE (`GDF_PD_WRITABLE)
    ) u_pd_bits (
        .pinMode  (pdMode),
        .stored   (state_q.pdData),
        .pinLevel (pdLevel),
        .readVal  (pdRead),
        .driveEn  (pdDrive),
        .pullupEn (pdPullup)
    );

    gdf_port_bits #(
        .WIDTH    (8),
        .WRITABLE (`GDF_PE_WRITABLE)
    ) u_pe_bits (
        .pinMode  (peMode),
        .stored   (state_q.peData),
        .pinLevel (peLevel),
        .readVal  (peRead),
        .driveEn  (peDrive),
        .pullupEn (pePullup)
    );

    gdf_port_bits #(
        .WIDTH    (8),
        .WRITABLE (`GDF_PF_WRITABLE)
    ) u_pf_bits (
        .pinMode  (pfMode),
        .stored   (8'h00),
        .pinLevel (pfLevel),
        .readVal  (pfRead),
        .driveEn  (),
        .pullupEn (pfPullup)
    );

    // port G data lives elsewhere; only its pull-ups are decoded here
    gdf_port_bits #(
        .WIDTH    (8),
        .WRITABLE (`GDF_PG_WRITABLE)
    ) u_pg_bits (
        .pinMode  (pgMode),
        .stored   (8'h00),
        .pinLevel (8'h00),
        .readVal  (),
        .driveEn  (),
        .pullupEn (pgPullup)
    );

    ////////////////////////////////////////////////////////////////////
    // address decode

    logic hitPd;
    logic hitPe;
    logic hitPf;
    logic hitAny;
    logic sizeOk;
    logic take;

    assign hitPd  = (busAddr == `GDF_ADDR_PORT_D);
    assign hitPe  = (busAddr == `GDF_ADDR_PORT_E);
    assign hitPf  = (busAddr == `GDF_ADDR_PORT_F);
    assign hitAny = hitPd || hitPe || hitPf;
    assign sizeOk = (busSize == `GDF_SIZE_BYTE);
    assign take   = busReq && (state_q.busState == GDF_BUS_IDLE);

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_d     = state_q;
        state_d.ack = 1'b0;
        state_d.err = 1'b0;

        unique case (state_q.busState)
            GDF_BUS_IDLE:
            begin
                if (take)
                begin
                    state_d.busState = GDF_BUS_RESP;
                    state_d.ack      = 1'b1;
                    state_d.err      = !(hitAny && sizeOk);
                    state_d.rdata    = `GDF_RDATA_NONE;

                    if (hitAny && sizeOk && busWrite)
                    begin
                        // stored in every mode; the pin follows only
                        // through the output enable
                        if (hitPd)
                        begin
                            state_d.pdData = busWdata
                                           & `GDF_PD_WRITABLE;
                        end
                        if (hitPe)
                        begin
                            state_d.peData = busWdata;
                        end
                        // port F writes are dropped here
                    end
                    else if (hitAny && sizeOk)
                    begin
                        if (hitPd)
                        begin
                            state_d.rdata = pdRead;
                        end
                        else if (hitPe)
                        begin
                            state_d.rdata = peRead;
                        end
                        else
                        begin
                            state_d.rdata = pfRead;
                        end
                    end
                end
            end

            GDF_BUS_RESP:
            begin
                state_d.busState = GDF_BUS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    // only power-on reset clears the stores; modes after it come from
    // the pin function controller as input with pull-up
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q.busState <= GDF_BUS_IDLE;
            state_q.pdData   <= `GDF_PD_RESET;
            state_q.peData   <= `GDF_PE_RESET;
            state_q.rdata    <= `GDF_RDATA_NONE;
            state_q.ack      <= 1'b0;
            state_q.err      <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign busRdata = state_q.rdata;
    assign busAck   = state_q.ack;
    assign busErr   = state_q.err;

    // input-only bits never drive
    assign pdPinOut = state_q.pdData;
    assign pdPinOe  = pdDrive;
    assign pePinOut = state_q.peData;
    assign pePinOe  = peDrive;

endmodule // gdf_port_data

// ---- testbench/gdf_port_data_checker.sv ----
/*
  Port checks of gdf_port_data.
  Assumes a bind to that module; sys_rst is its only reset.
*/
`include "gdf_params.svh"

module gdf_port_data_checker
    import gdf_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // bus
    input wire logic        busReq,
    input wire logic        busWrite,
    input wire logic [31:0] busAddr,
    input wire logic [1:0]  busSize,
    input wire logic [7:0]  busWdata,
    input wire logic [7:0]  busRdata,
    input wire logic        busAck,
    input wire logic        busErr,
    // modes and pins
    input wire logic [15:0] pdMode,
    input wire logic [15:0] peMode,
    input wire logic [15:0] pfMode,
    input wire logic [15:0] pgMode,
    input wire logic [7:0]  pdPinOut,
    input wire logic [7:0]  pdPinOe,
    input wire logic [7:0]  pePinOut,
    input wire logic [7:0]  pePinOe,
    input wire logic [7:0]  pfPullup,
    input wire logic [7:0]  pgPullup
);
    timeunit 1ns;
    timeprecision 1ns;
    logic taken;
    logic peWr;
    assign taken = busReq && !busAck;
    assign peWr = taken && busWrite && busSize == `GDF_SIZE_BYTE
                  && busAddr == `GDF_ADDR_PORT_E;

    // bit n set where pin n has mode m
    function automatic logic [7:0] modeIs(logic [15:0] md, logic [1:0] m);
        for (int n = 0; n < 8; n++)
            modeIs[n] = md[2*n +: 2] == m;
    endfunction

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    chk_ack_next: assert property (taken |=> busAck)
        else $error("request not answered");
    chk_ack_cause: assert property (busAck |-> $past(taken))
        else $error("answer without request");
    chk_size_err: assert property (taken && busSize != 2'h0
        |=> busErr && busRdata == 8'h00) else $error("size not refused");
    chk_pd_drive: assert property (pdPinOe == (modeIs(pdMode, 2'h1)
        & `GDF_PD_WRITABLE)) else $error("pd enable wrong");
    chk_pe_drive: assert property (pePinOe == modeIs(peMode, 2'h1))
        else $error("pe enable wrong");
    chk_pull_on: assert property (pfPullup == modeIs(pfMode, 2'h2)
        && pgPullup == modeIs(pgMode, 2'h2)) else $error("pull-up wrong");
    chk_pe_store: assert property (peWr
        |=> pePinOut == $past(busWdata)) else $error("pe write lost");
    chk_pe_hold: assert property (!peWr |=> $stable(pePinOut))
        else $error("pe store moved");
    chk_pd_ro_low: assert property ((pdPinOut & 8'h50) == 8'h00)
        else $error("pd input bit driven");
    chk_pf_masked: assert property (taken && !busWrite
        && busAddr == `GDF_ADDR_PORT_F |=> (busRdata & ~(modeIs($past(pfMode),
        2'h2) | modeIs($past(pfMode), 2'h3))) == 8'h00)
        else $error("pf reads non-input bit");

    cover property (peWr);
    cover property (busAck && busErr);
    cover property (taken && busAddr == `GDF_ADDR_PORT_F);
endmodule // gdf_port_data_checker

// ---- testbench/gdf_pin_model.sv ----
/*
  Outside of one port: the level on each pin.
  Assumes the bench sets extLevel/extEn; a pin nobody drives or pulls
  toggles every cycle so a stale level never reads as valid.
*/
module gdf_pin_model
(
    // clock
    input wire logic       sys_clk,
    // block side
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullEn,
    // outside drivers
    input wire logic [7:0] extLevel,
    input wire logic [7:0] extEn,
    // pin level
    output logic     [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_q = 8'h00;
    always @(posedge sys_clk)
        last_q <= pinIn;
    // port drive wins, then outside drivers, then pull-up
    assign pinIn = (pinOe & pinOut)
                 | (~pinOe & extEn & extLevel)
                 | (~pinOe & ~extEn & pullEn)
                 | (~pinOe & ~extEn & ~pullEn & ~last_q);
endmodule // gdf_pin_model

// ---- testbench/testbench.sv ----
/*
  Self-checking bench of gdf_port_data with pin models on D, E and F.
  Assumes each byte access is answered one cycle after it is taken.
*/
`include "gdf_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        busReq = 1'b0;
    logic        busWrite = 1'b0;
    logic [31:0] busAddr = 32'h0;
    logic [1:0]  busSize = 2'h0;
    logic [7:0]  busWdata = 8'h00;
    logic [7:0]  busRdata, rd, pdPinIn, pdPinOut, pdPinOe, pdPullup;
    logic [7:0]  pePinIn, pePinOut, pePinOe, pePullup, pfPinIn, pfPullup;
    logic [7:0]  pgPullup, extD = 8'hFF, extE = 8'h00, extF = 8'h00;
    logic [7:0]  enD = 8'hFF;
    logic [15:0] pdMode = 16'hAAAA, peMode = 16'hAAAA;
    logic [15:0] pfMode = 16'hAAAA, pgMode = 16'hAAAA;
    logic        busAck, busErr, er;
    int          errCount = 0, nCompared = 0, cycles = 0;

    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end

    gdf_port_data u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
        .busSize(busSize), .busWdata(busWdata), .busRdata(busRdata),
        .busAck(busAck), .busErr(busErr), .pdMode(pdMode), .peMode(peMode),
        .pfMode(pfMode), .pgMode(pgMode), .pdPinIn(pdPinIn),
        .pdPinOut(pdPinOut), .pdPinOe(pdPinOe), .pdPullup(pdPullup),
        .pePinIn(pePinIn), .pePinOut(pePinOut), .pePinOe(pePinOe),
        .pePullup(pePullup), .pfPinIn(pfPinIn), .pfPullup(pfPullup),
        .pgPullup(pgPullup));
    gdf_pin_model u_pd (.sys_clk(sys_clk), .pinOut(pdPinOut),
        .pinOe(pdPinOe), .pullEn(pdPullup), .extLevel(extD),
        .extEn(enD), .pinIn(pdPinIn));
    gdf_pin_model u_pe (.sys_clk(sys_clk), .pinOut(pePinOut),
        .pinOe(pePinOe), .pullEn(pePullup), .extLevel(extE),
        .extEn(8'hFF), .pinIn(pePinIn));
    gdf_pin_model u_pf (.sys_clk(sys_clk), .pinOut(8'h00), .pinOe(8'h00),
        .pullEn(pfPullup), .extLevel(extF), .extEn(8'hFF), .pinIn(pfPinIn));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, exp);
        nCompared++;
        if (seen !== exp)
        begin
            errCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one byte access, held until the answer is sampled
    task automatic access(input logic wr, input logic [31:0] a,
                          input logic [1:0] sz, input logic [7:0] wd);
        int k;
        @(posedge sys_clk);
        busReq <= 1'b1;
        busWrite <= wr;
        busAddr <= a;
        busSize <= sz;
        busWdata <= wd;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (busAck !== 1'b1 && k < 8);
        rd = busRdata;
        er = busErr;
        busReq <= 1'b0;
        check(8'(k), 8'h02);
    endtask

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        tick(4);
        check(pdPinOut, `GDF_PD_RESET);
        check(pdPullup, 8'hFF);
        access(1'b0, `GDF_ADDR_PORT_D, 2'h0, 8'h00);
        check(rd, 8'hFF);
        peMode <= 16'h0000;
        access(1'b0, `GDF_ADDR_PORT_E, 2'h0, 8'h00);
        check(rd, `GDF_PE_RESET);
        $display("t_reset done");
    endtask

    task automatic t_portd();
        pdMode <= 16'h5555;
        access(1'b1, `GDF_ADDR_PORT_D, 2'h0, 8'hFF);
        tick(5);
        check(pdPinOut, 8'hAF);
        check(pdPinOe, 8'hAF);
        access(1'b0, `GDF_ADDR_PORT_D, 2'h0, 8'h00);
        check(rd, 8'hAF);
        pdMode <= 16'h0000;
        access(1'b1, `GDF_ADDR_PORT_D, 2'h0, 8'h21);
        tick(1);
        check(pdPinOe, 8'h00);
        access(1'b0, `GDF_ADDR_PORT_D, 2'h0, 8'h00);
        check(rd, 8'h21);
        pdMode <= 16'hFFFF;
        extD <= 8'h50;
        tick(4);
        access(1'b0, `GDF_ADDR_PORT_D, 2'h0, 8'h00);
        check(rd, 8'h50);
        // upper nibble left floating, held high by the pull-ups
        enD <= 8'h0F;
        pdMode <= 16'hAAAA;
        tick(4);
        access(1'b0, `GDF_ADDR_PORT_D, 2'h0, 8'h00);
        check(rd, 8'hF0);
        $display("t_portd done");
    endtask

    task automatic t_porte();
        peMode <= 16'hFFFF;
        extE <= 8'h3C;
        access(1'b1, `GDF_ADDR_PORT_E, 2'h0, 8'hC3);
        tick(4);
        check(pePinOe, 8'h00);
        check(pePullup, 8'h00);
        access(1'b0, `GDF_ADDR_PORT_E, 2'h0, 8'h00);
        check(rd, 8'h3C);
        peMode <= 16'h5555;
        access(1'b0, `GDF_ADDR_PORT_E, 2'h0, 8'h00);
        check(rd, 8'hC3);
        check(pePinOe, 8'hFF);
        check(pePinOut, 8'hC3);
        $display("t_porte done");
    endtask

    task automatic t_portf();
        extF <= 8'hA5;
        for (int m = 0; m < 4; m++)
        begin
            pfMode <= {8{m[1:0]}};
            pgMode <= {8{m[1:0]}};
            tick(4);
            access(1'b1, `GDF_ADDR_PORT_F, 2'h0, 8'hFF);
            check({7'h0, er}, 8'h00);
            access(1'b0, `GDF_ADDR_PORT_F, 2'h0, 8'h00);
            check(rd, m[1] ? 8'hA5 : 8'h00);
            check(pfPullup, m == 2 ? 8'hFF : 8'h00);
            check(pgPullup, m == 2 ? 8'hFF : 8'h00);
        end
        $display("t_portf done");
    endtask

    task automatic t_refuse();
        access(1'b1, `GDF_ADDR_PORT_E, 2'h1, 8'h11);
        check({7'h0, er}, 8'h01);
        access(1'b0, 32'h0400_012C, 2'h0, 8'h00);
        check({7'h0, er}, 8'h01);
        check(rd, `GDF_RDATA_NONE);
        access(1'b0, `GDF_ADDR_PORT_E, 2'h0, 8'h00);
        check(rd, 8'hC3);
        $display("t_refuse done");
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errCount++;
            $display("Error at %0t: timeout", $time);
            end_of_test();
        end
    end

    initial
    begin
        tick(20);
        sys_rst <= 1'b0;
        t_reset();
        t_portd();
        t_porte();
        t_portf();
        t_refuse();
        end_of_test();
    end
endmodule // testbench

bind gdf_port_data gdf_port_data_checker u_chk (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .busReq(busReq), .busWrite(busWrite),
    .busAddr(busAddr), .busSize(busSize), .busWdata(busWdata),
    .busRdata(busRdata), .busAck(busAck), .busErr(busErr),
    .pdMode(pdMode), .peMode(peMode), .pfMode(pfMode), .pgMode(pgMode),
    .pdPinOut(pdPinOut), .pdPinOe(pdPinOe), .pePinOut(pePinOut),
    .pePinOe(pePinOe), .pfPullup(pfPullup), .pgPullup(pgPullup));
